// ### verilog/fpcx_defines.svh
`ifndef FPCX_DEFINES_SVH
`define FPCX_DEFINES_SVH

// ==========================================
// Register port map
`define FPCX_REG_STATUS 3'h0
`define FPCX_REG_CLEAR  3'h1
`define FPCX_REG_ENABLE 3'h2
`define FPCX_REG_MASK   3'h3
`define FPCX_REG_COND   3'h4

// ==========================================
// Exception bit positions in status, enable and clear; mask holds IE to PE only, no SF bit
`define FPCX_BIT_IE 0
`define FPCX_BIT_DE 1
`define FPCX_BIT_ZE 2
`define FPCX_BIT_OE 3
`define FPCX_BIT_UE 4
`define FPCX_BIT_PE 5
`define FPCX_BIT_SF 6
`define FPCX_MASK_RST 6'h3f

// ==========================================
// Opcodes
`define FPCX_OP_PREFIX   8'hd9
`define FPCX_OP_CLASSIFY 8'he5
`define FPCX_OP_SWAP     5'h19
`define FPCX_OP_EXTRACT  8'hf4
`define FPCX_OP_LOG      8'hf1

// ==========================================
// Class codes, bit order cond_c3, cond_c2, cond_c0
`define FPCX_CLS_UNSUP  3'h0
`define FPCX_CLS_NAN    3'h1
`define FPCX_CLS_NORM   3'h2
`define FPCX_CLS_INF    3'h3
`define FPCX_CLS_ZERO   3'h4
`define FPCX_CLS_EMPTY  3'h5
`define FPCX_CLS_DENORM 3'h6

// ==========================================
// Extended format
`define FPCX_BIAS     15'h3fff
`define FPCX_EXP_MAX  15'h7fff
`define FPCX_ONE_MANT 64'h8000_0000_0000_0000
`define FPCX_QUIET    80'h0000_4000_0000_0000_0000
`define FPCX_INDEF    80'hffff_c000_0000_0000_0000
`define FPCX_FRAC_BITS 62

`endif

// ### verilog/fpcx_pkg.sv
package fpcx_pkg;

	typedef enum logic [1:0]
	{
		FPCX_S_IDLE = 2'b00,
		FPCX_S_SQ   = 2'b01,
		FPCX_S_FIN  = 2'b10
	} fpcx_state_e;

	typedef enum logic [2:0]
	{
		FPCX_OP_NONE     = 3'b000,
		FPCX_OP_CLASSIFY = 3'b001,
		FPCX_OP_SWAP     = 3'b010,
		FPCX_OP_EXTRACT  = 3'b011,
		FPCX_OP_LOG      = 3'b100
	} fpcx_op_e;

	typedef struct packed
	{
		fpcx_state_e       state;
		logic [7:0][79:0]  st;
		logic [7:0]        empty;
		logic [2:0]        top;
		logic [3:0]        cond;
		logic [6:0]        status;
		logic [6:0]        enable;
		logic [5:0]        mask;
		logic [7:0]        rdata;
		logic              done;
		logic              nm;
		logic [5:0]        cnt;
		logic [63:0]       m;
		logic [79:0]       lfix;
		logic [63:0]       ym;
		logic [16:0]       ye;
		logic              ys;
	} fpcx_regs_s;

endpackage

// ### verilog/fpcx_unit.sv
`timescale 1ns/1ps
`include "fpcx_defines.svh"

module fpcx_unit
	import fpcx_pkg::*;
#(
	parameter int FRAC_BITS = `FPCX_FRAC_BITS
)
(
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        op_valid,
	input  wire logic [7:0]  op_byte0,
	input  wire logic [7:0]  op_byte1,
	output logic             op_ready,
	input  wire logic        push_valid,
	input  wire logic [79:0] push_data,
	input  wire logic [2:0]  rd_index,
	output logic [79:0]      rd_data,
	output logic             rd_empty,
	input  wire logic        emu_bit,
	input  wire logic        task_switched_bit,
	output logic             done,
	output logic             device_unavail_exc,
	output logic             cond_c0,
	output logic             cond_c1,
	output logic             cond_c2,
	output logic             cond_c3,
	output logic [2:0]       stack_top_ptr,
	input  wire logic [2:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [7:0]       reg_rdata,
	output logic             irq
);

	if (FRAC_BITS < 8 || FRAC_BITS > 62)
	begin : g_bad_frac
		$error("FRAC_BITS must lie in 8..62");
	end

	fpcx_regs_s r_reg;
	fpcx_regs_s r_next;

	// ==========================================
	// Helpers
	function automatic logic [6:0] fpcx_lzc(input logic [79:0] v);
		logic [6:0] n;
		logic       hit;
		n = 7'd80;
		hit = 1'b0;
		for (int k = 79; k >= 0; k--)
		begin
			if (!hit && v[k])
			begin
				n = 7'(79 - k);
				hit = 1'b1;
			end
		end
		return n;
	endfunction

	function automatic logic [79:0] fpcx_int2ext(input logic [16:0] e);
		logic [15:0] a;
		logic [6:0]  lz;
		logic [63:0] mn;
		a = e[16] ? 16'(-e) : e[15:0];
		lz = fpcx_lzc({a, 64'h0});
		mn = {a, 48'h0} << lz;
		if (a == 16'h0)
			return 80'h0;
		return {e[16], 15'(16'h3fff + 16'h000f - {9'h0, lz}), mn};
	endfunction

	function automatic logic [2:0] fpcx_class(input logic [79:0] v, input logic emp);
		if (emp)
			return `FPCX_CLS_EMPTY;
		if (v[78:64] == `FPCX_EXP_MAX)
		begin
			if (!v[63])
				return `FPCX_CLS_UNSUP;
			return (v[62:0] == 63'h0) ? `FPCX_CLS_INF : `FPCX_CLS_NAN;
		end
		if (v[78:64] == 15'h0)
			return (v[63:0] == 64'h0) ? `FPCX_CLS_ZERO : `FPCX_CLS_DENORM;
		return v[63] ? `FPCX_CLS_NORM : `FPCX_CLS_UNSUP;
	endfunction

	function automatic fpcx_op_e fpcx_decode(input logic [7:0] b0, input logic [7:0] b1);
		if (b0 != `FPCX_OP_PREFIX)
			return FPCX_OP_NONE;
		if (b1 == `FPCX_OP_CLASSIFY)
			return FPCX_OP_CLASSIFY;
		if (b1[7:3] == `FPCX_OP_SWAP)
			return FPCX_OP_SWAP;
		if (b1 == `FPCX_OP_EXTRACT)
			return FPCX_OP_EXTRACT;
		if (b1 == `FPCX_OP_LOG)
			return FPCX_OP_LOG;
		return FPCX_OP_NONE;
	endfunction

	// ==========================================
	// Next state
	always_comb
	begin
		logic [2:0]   pt;
		logic [2:0]   p1;
		logic [2:0]   pm;
		logic [2:0]   si;
		logic [79:0]  x;
		logic [79:0]  y;
		logic [79:0]  lres;
		logic [79:0]  labs;
		logic [79:0]  lsh;
		logic [2:0]   xc;
		logic [2:0]   yc;
		logic [6:0]   set;
		logic [6:0]   clr;
		logic [6:0]   xlz;
		logic [6:0]   ylz;
		logic [6:0]   llz;
		logic [16:0]  xe;
		logic [16:0]  ye;
		logic [63:0]  xmn;
		logic [63:0]  ymn;
		logic [63:0]  lm;
		logic [63:0]  mant;
		logic [127:0] sq;
		logic [127:0] prod;
		logic [64:0]  mr;
		logic [17:0]  le;
		logic [17:0]  re;
		logic         lwr;
		logic         lpop;
		logic         inv;
		logic         g;
		logic         stk;
		logic         rnd;
		logic         inx;
		logic         rs;
		logic         lt1;
		logic         xsn;
		logic         ysn;
		fpcx_op_e     opc;
		r_next = r_reg;
		r_next.done = 1'b0;
		r_next.nm = 1'b0;
		pt = r_reg.top;
		p1 = pt + 3'h1;
		pm = pt - 3'h1;
		si = pt + op_byte1[2:0];
		x = r_reg.st[pt];
		y = r_reg.st[p1];
		xc = fpcx_class(x, r_reg.empty[pt]);
		yc = fpcx_class(y, r_reg.empty[p1]);
		xsn = (xc == `FPCX_CLS_UNSUP) || (xc == `FPCX_CLS_NAN && !x[62]);
		ysn = (yc == `FPCX_CLS_UNSUP) || (yc == `FPCX_CLS_NAN && !y[62]);
		xlz = fpcx_lzc({x[63:0], 16'h0});
		ylz = fpcx_lzc({y[63:0], 16'h0});
		xmn = x[63:0] << xlz;
		ymn = y[63:0] << ylz;
		// Denormals are normalised so both paths share one exponent form
		xe = (x[78:64] == 15'h0) ? (17'h1 - 17'h3fff - {10'h0, xlz}) : ({2'b0, x[78:64]} - 17'h3fff);
		ye = (y[78:64] == 15'h0) ? (17'h1 - 17'h3fff - {10'h0, ylz}) : ({2'b0, y[78:64]} - 17'h3fff);
		lt1 = x[78:64] < `FPCX_BIAS;
		opc = fpcx_decode(op_byte0, op_byte1);
		set = 7'h0;
		clr = 7'h0;
		lres = `FPCX_INDEF;
		lwr = 1'b0;
		lpop = 1'b0;
		inv = 1'b0;
		sq = r_reg.m * r_reg.m;
		labs = r_reg.lfix[79] ? 80'(~r_reg.lfix + 80'h1) : r_reg.lfix;
		llz = fpcx_lzc(labs);
		lsh = labs << llz;
		lm = lsh[79:16];
		prod = lm * r_reg.ym;
		mant = prod[127] ? prod[127:64] : prod[126:63];
		g = prod[127] ? prod[63] : prod[62];
		stk = prod[127] ? (|prod[62:0]) : (|prod[61:0]);
		rnd = g & (stk | mant[0]);
		mr = {1'b0, mant} + {64'h0, rnd};
		le = 18'h0400e - {11'h0, llz};
		re = le + {r_reg.ye[16], r_reg.ye} + {17'h0, prod[127]} + {17'h0, mr[64]};
		inx = (|lsh[15:0]) | g | stk | (r_reg.m != `FPCX_ONE_MANT);
		rs = r_reg.lfix[79] ^ r_reg.ys;
		case (r_reg.state)
			FPCX_S_IDLE:
			begin
				if (op_valid)
				begin
					r_next.done = 1'b1;
					if (emu_bit | task_switched_bit)
						r_next.nm = 1'b1;
					else
					begin
						case (opc)
							FPCX_OP_CLASSIFY:
								r_next.cond = {xc[2], xc[1], x[79], xc[0]};
							FPCX_OP_SWAP:
							begin
								r_next.cond[1] = 1'b0;
								if (r_reg.empty[pt] | r_reg.empty[si])
									set = 7'h41;
								else
								begin
									r_next.st[pt] = r_reg.st[si];
									r_next.st[si] = x;
								end
							end
							FPCX_OP_EXTRACT:
							begin
								r_next.cond[1] = 1'b0;
								if (r_reg.empty[pt])
									set = 7'h41;
								else if (!r_reg.empty[pm])
								begin
									set = 7'h41;
									r_next.cond[1] = 1'b1;
								end
								else if (xsn || xc == `FPCX_CLS_NAN)
								begin
									set[`FPCX_BIT_IE] = xsn;
									if (!xsn || r_reg.mask[`FPCX_BIT_IE])
									begin
										lres = (xc == `FPCX_CLS_UNSUP) ? `FPCX_INDEF : (x | `FPCX_QUIET);
										r_next.st[pt] = lres;
										r_next.st[pm] = lres;
										r_next.empty[pm] = 1'b0;
										r_next.top = pm;
									end
								end
								else if (xc == `FPCX_CLS_ZERO)
								begin
									set[`FPCX_BIT_ZE] = 1'b1;
									if (r_reg.mask[`FPCX_BIT_ZE])
									begin
										r_next.st[pt] = {1'b1, `FPCX_EXP_MAX, `FPCX_ONE_MANT};
										r_next.st[pm] = {x[79], 79'h0};
										r_next.empty[pm] = 1'b0;
										r_next.top = pm;
									end
								end
								else
								begin
									set[`FPCX_BIT_DE] = (xc == `FPCX_CLS_DENORM);
									if (xc == `FPCX_CLS_INF)
									begin
										r_next.st[pt] = {1'b0, `FPCX_EXP_MAX, `FPCX_ONE_MANT};
										r_next.st[pm] = x;
									end
									else
									begin
										r_next.st[pt] = fpcx_int2ext(xe);
										r_next.st[pm] = {x[79], `FPCX_BIAS, xmn};
									end
									r_next.empty[pm] = 1'b0;
									r_next.top = pm;
								end
							end
							FPCX_OP_LOG:
							begin
								r_next.cond[1] = 1'b0;
								if (r_reg.empty[pt] | r_reg.empty[p1])
								begin
									set[`FPCX_BIT_SF] = 1'b1;
									inv = 1'b1;
								end
								else
								begin
									set[`FPCX_BIT_DE] = (xc == `FPCX_CLS_DENORM) || (yc == `FPCX_CLS_DENORM);
									lwr = 1'b1;
									if (xsn | ysn)
										inv = 1'b1;
									else if (xc == `FPCX_CLS_NAN || yc == `FPCX_CLS_NAN)
										lres = (xc == `FPCX_CLS_NAN) ? (x | `FPCX_QUIET) : (y | `FPCX_QUIET);
									else if (x[79] && xc != `FPCX_CLS_ZERO)
										inv = 1'b1;
									else if (xc == `FPCX_CLS_ZERO)
									begin
										lres = {~y[79], `FPCX_EXP_MAX, `FPCX_ONE_MANT};
										if (yc == `FPCX_CLS_ZERO)
											inv = 1'b1;
										else if (yc != `FPCX_CLS_INF)
										begin
											set[`FPCX_BIT_ZE] = 1'b1;
											lwr = r_reg.mask[`FPCX_BIT_ZE];
										end
									end
									else if (xc == `FPCX_CLS_INF)
									begin
										inv = (yc == `FPCX_CLS_ZERO);
										lres = {y[79], `FPCX_EXP_MAX, `FPCX_ONE_MANT};
									end
									else if (yc == `FPCX_CLS_INF)
									begin
										inv = (x[78:0] == {`FPCX_BIAS, `FPCX_ONE_MANT});
										lres = {y[79] ^ lt1, `FPCX_EXP_MAX, `FPCX_ONE_MANT};
									end
									else if (yc == `FPCX_CLS_ZERO)
										lres = {y[79] ^ lt1, 79'h0};
									else
									begin
										// Finite positive by finite: iterate on the significand
										lwr = 1'b0;
										r_next.done = 1'b0;
										r_next.m = xmn;
										r_next.lfix = {xe[15:0], 64'h0};
										r_next.ym = ymn;
										r_next.ye = ye;
										r_next.ys = y[79];
										r_next.cnt = 6'h0;
										r_next.state = FPCX_S_SQ;
									end
								end
								if (inv)
								begin
									set[`FPCX_BIT_IE] = 1'b1;
									lres = `FPCX_INDEF;
									lwr = r_reg.mask[`FPCX_BIT_IE];
								end
								lpop = lwr;
							end
							default:
							begin
							end
						endcase
					end
				end
				else if (push_valid)
				begin
					if (!r_reg.empty[pm])
					begin
						set = 7'h41;
						r_next.cond[1] = 1'b1;
					end
					else
					begin
						r_next.st[pm] = push_data;
						r_next.empty[pm] = 1'b0;
						r_next.top = pm;
					end
				end
			end
			FPCX_S_SQ:
			begin
				// One fraction bit of log2 per cycle by repeated squaring
				if (sq[127])
				begin
					r_next.m = sq[127:64];
					r_next.lfix[7'd63 - {1'b0, r_reg.cnt}] = 1'b1;
				end
				else
					r_next.m = sq[126:63];
				r_next.cnt = r_reg.cnt + 6'h1;
				if (r_reg.cnt == 6'(FRAC_BITS - 1))
					r_next.state = FPCX_S_FIN;
			end
			FPCX_S_FIN:
			begin
				r_next.state = FPCX_S_IDLE;
				r_next.done = 1'b1;
				lwr = 1'b1;
				lpop = 1'b1;
				r_next.cond[1] = 1'b0;
				if (labs == 80'h0)
					lres = {r_reg.ys, 79'h0};
				else if (!re[17] && re >= 18'h07fff)
				begin
					set[`FPCX_BIT_OE] = 1'b1;
					set[`FPCX_BIT_PE] = 1'b1;
					lres = {rs, `FPCX_EXP_MAX, `FPCX_ONE_MANT};
				end
				else if (re[17] || re == 18'h0)
				begin
					set[`FPCX_BIT_UE] = 1'b1;
					set[`FPCX_BIT_PE] = 1'b1;
					lres = {rs, 79'h0};
				end
				else
				begin
					lres = {rs, re[14:0], mr[64] ? `FPCX_ONE_MANT : mr[63:0]};
					set[`FPCX_BIT_PE] = inx;
					r_next.cond[1] = inx & rnd;
				end
			end
			default:
				r_next.state = FPCX_S_IDLE;
		endcase
		if (lwr)
			r_next.st[p1] = lres;
		if (lpop)
		begin
			r_next.empty[pt] = 1'b1;
			r_next.top = p1;
		end

		// ==========================================
		// Register port
		r_next.rdata = 8'h0;
		if (reg_rd)
		begin
			case (reg_addr)
				`FPCX_REG_STATUS: r_next.rdata = {1'b0, r_reg.status};
				`FPCX_REG_ENABLE: r_next.rdata = {1'b0, r_reg.enable};
				`FPCX_REG_MASK:   r_next.rdata = {2'b0, r_reg.mask};
				`FPCX_REG_COND:   r_next.rdata = {1'b0, r_reg.top, r_reg.cond};
				default:          r_next.rdata = 8'h0;
			endcase
		end
		if (reg_wr)
		begin
			case (reg_addr)
				`FPCX_REG_CLEAR:  clr = reg_wdata[6:0];
				`FPCX_REG_ENABLE: r_next.enable = reg_wdata[6:0];
				`FPCX_REG_MASK:   r_next.mask = reg_wdata[5:0];
				default:
				begin
				end
			endcase
		end
		// Set beats a clear in the same cycle
		r_next.status = (r_reg.status & ~clr) | set;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			r_reg <= '0;
			r_reg.empty <= 8'hff;
			r_reg.mask <= `FPCX_MASK_RST;
		end
		else
			r_reg <= r_next;
	end

	// ==========================================
	// Outputs
	assign op_ready = (r_reg.state == FPCX_S_IDLE);
	assign rd_data = r_reg.st[r_reg.top + rd_index];
	assign rd_empty = r_reg.empty[r_reg.top + rd_index];
	assign done = r_reg.done;
	assign device_unavail_exc = r_reg.nm;
	assign {cond_c3, cond_c2, cond_c1, cond_c0} = r_reg.cond;
	assign stack_top_ptr = r_reg.top;
	assign reg_rdata = r_reg.rdata;
	assign irq = |(r_reg.status & r_reg.enable);

endmodule

// ### test/fpcx_dispatch.sv
`timescale 1ns/1ps
// ==========================================
// Dispatch model: offers one opcode after a programmable delay
module fpcx_dispatch
(
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       req,
	input  wire logic [7:0] b1,
	input  wire logic [3:0] gap,
	input  wire logic       op_ready,
	output logic            op_valid,
	output logic [7:0]      op_byte0,
	output logic [7:0]      op_byte1
);
	logic       busy;
	logic [3:0] cnt;
	logic [7:0] last;

	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
		begin
			op_valid <= 1'b0;
			busy     <= 1'b0;
			cnt      <= 4'h0;
			last     <= 8'h00;
		end
		else if (req)
		begin
			busy <= 1'b1;
			cnt  <= gap;
			last <= b1;
		end
		else if (busy && !op_valid)
		begin
			if (cnt == 4'h0)
				op_valid <= 1'b1;
			else
				cnt <= cnt - 4'h1;
		end
		else if (op_valid && op_ready)
		begin
			op_valid <= 1'b0;
			busy     <= 1'b0;
		end

	// Idle bytes are inverted so a stale opcode never looks valid
	assign op_byte0 = op_valid ? 8'hd9 : 8'h26;
	assign op_byte1 = op_valid ? last : ~last;
endmodule

// ### test/fpcx_unit_props.sv
`timescale 1ns/1ps
module fpcx_unit_props
	import fpcx_pkg::*;
#(
	parameter int FRAC_BITS = 62
)
(
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic        op_valid,
	input wire logic [7:0]  op_byte0,
	input wire logic [7:0]  op_byte1,
	input wire logic        op_ready,
	input wire logic [2:0]  rd_index,
	input wire logic [79:0] rd_data,
	input wire logic        rd_empty,
	input wire logic        emu_bit,
	input wire logic        task_switched_bit,
	input wire logic        done,
	input wire logic        device_unavail_exc,
	input wire logic        cond_c0,
	input wire logic        cond_c1,
	input wire logic        cond_c2,
	input wire logic        cond_c3,
	input wire logic [2:0]  stack_top_ptr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata
);
	localparam int LOG_MAX = FRAC_BITS + 2;
	logic take;
	logic ctl;
	logic top_sign;

	assign take = op_valid && op_ready && op_byte0 == 8'hd9;
	assign ctl = emu_bit || task_switched_bit;
	assign top_sign = rd_data[79];

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	a_fault_on_ctrl: assert property (take && ctl |=> device_unavail_exc && done)
		else $error("control bit set but no fault");
	a_no_stray_fault: assert property (take && !ctl |=> !device_unavail_exc)
		else $error("fault without control bit");
	a_classify_sign: assert property (take && !ctl && op_byte1 == 8'he5 && rd_index == 3'h0
		|=> done && cond_c1 == $past(top_sign))
		else $error("classify sign wrong");
	a_classify_empty: assert property (take && !ctl && op_byte1 == 8'he5 && rd_index == 3'h0
		&& rd_empty |=> {cond_c3, cond_c2, cond_c0} == 3'h5)
		else $error("empty class wrong");
	a_swap_keeps_top: assert property (take && !ctl && op_byte1[7:3] == 5'h19
		|=> done && !cond_c1 && $stable(stack_top_ptr))
		else $error("swap flags or top wrong");
	// Only sources that always push or overflow: normal, pseudo-denormal, never max exponent
	a_extract_push: assert property (take && !ctl && op_byte1 == 8'hf4 && rd_index == 3'h0
		&& !rd_empty && rd_data[63] && rd_data[78:64] != 15'h7fff
		|=> done && (stack_top_ptr == $past(stack_top_ptr) - 3'h1 || cond_c1))
		else $error("extract push wrong");
	a_log_bounded: assert property ($fell(op_ready) |-> ##[1:LOG_MAX] done)
		else $error("log never finished");
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data outside read slot");
endmodule

bind fpcx_unit fpcx_unit_props #(.FRAC_BITS(FRAC_BITS)) i_props (.clk, .resetn, .op_valid,
	.op_byte0, .op_byte1, .op_ready, .rd_index, .rd_data, .rd_empty, .emu_bit,
	.task_switched_bit, .done, .device_unavail_exc, .cond_c0, .cond_c1, .cond_c2,
	.cond_c3, .stack_top_ptr, .reg_rd, .reg_rdata);

// ### test/testbench.sv
`timescale 1ns/1ps
module testbench;
	import fpcx_pkg::*;
	localparam logic [79:0] ONE = 80'h3fff_8000_0000_0000_0000;
	localparam logic [79:0] VALS [6] = '{ONE, 80'h7fff_8000_0000_0000_0000, 80'h0,
		80'h1, 80'h7fff_c000_0000_0000_0000, 80'h4000_0000_0000_0000_0000};
	localparam logic [2:0] CLS [6] = '{3'h2, 3'h3, 3'h4, 3'h6, 3'h1, 3'h0};
	logic        clk, resetn, req, push_valid, emu_bit, task_switched_bit, reg_wr, reg_rd;
	logic        op_valid, op_ready, rd_empty, done, device_unavail_exc, irq, s;
	logic        cond_c0, cond_c1, cond_c2, cond_c3;
	logic [7:0]  b1, reg_wdata, op_byte0, op_byte1, reg_rdata, mm;
	logic [3:0]  gap;
	logic [2:0]  rd_index, reg_addr, stack_top_ptr;
	logic [79:0] push_data, rd_data;
	logic [79:0] pushed [6];
	logic [7:0]  q_v [$];
	logic [7:0]  q_m [$];
	int          err_count, n_checks;

	fpcx_unit #(.FRAC_BITS(8)) i_dut (.clk, .resetn, .op_valid, .op_byte0, .op_byte1,
		.op_ready, .push_valid, .push_data, .rd_index, .rd_data, .rd_empty, .emu_bit,
		.task_switched_bit, .done, .device_unavail_exc, .cond_c0, .cond_c1, .cond_c2,
		.cond_c3, .stack_top_ptr, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);
	fpcx_dispatch i_disp (.clk, .resetn, .req, .b1, .gap, .op_ready, .op_valid, .op_byte0,
		.op_byte1);

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic check(string n, logic [79:0] e, logic [79:0] g);
		n_checks++;
		if (g !== e)
		begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	function automatic logic [7:0] ev(logic [2:0] c, logic sg, logic [2:0] t);
		return {1'b0, c[2], c[1], sg, c[0], t};
	endfunction

	// ==========================================
	// Drivers
	task automatic op(logic [7:0] b, logic [7:0] v, logic [7:0] m);
		int k;
		q_v.push_back(v);
		q_m.push_back(m);
		req <= 1'b1;
		b1 <= b;
		gap <= 4'($urandom % 4);
		@(posedge clk);
		req <= 1'b0;
		for (k = 0; k < 200 && q_v.size() > 0; k++)
			@(posedge clk);
		if (k == 200)
		begin
			err_count++;
			complete_run();
		end
		@(posedge clk);
	endtask

	task automatic push(logic [79:0] d);
		push_valid <= 1'b1;
		push_data <= d;
		@(posedge clk);
		push_valid <= 1'b0;
		push_data <= ~d;
		@(posedge clk);
	endtask

	task automatic wr(logic [2:0] a, logic [7:0] d);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		// Idle edge so back-to-back calls never drive reg_wr twice in one step
		@(posedge clk);
	endtask

	task automatic rd(logic [2:0] a, logic [7:0] e, string n);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		check(n, e, reg_rdata);
	endtask

	// Oldest note is matched against each done pulse
	always @(posedge clk)
		if (done === 1'b1)
		begin
			if (q_v.size() == 0)
				check("spurious_done", 80'h0, 80'h1);
			else
			begin
				mm = q_m.pop_front();
				check("op_result", q_v.pop_front() & mm, {device_unavail_exc, cond_c3,
					cond_c2, cond_c1, cond_c0, stack_top_ptr} & mm);
			end
		end

	// ==========================================
	// Main sequence
	initial
	begin
		{resetn, req, push_valid, emu_bit, task_switched_bit, reg_wr, reg_rd} = 7'h0;
		{b1, reg_wdata, gap, rd_index, reg_addr, push_data} = '0;
		void'($urandom(32'h1957));
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		check("ready", 80'h1, op_ready);
		rd(3'h3, 8'h3f, "mask");
		rd(3'h5, 8'h00, "unmapped");
		op(8'he5, ev(3'h5, 1'b0, 3'h0), 8'hff);
		for (int i = 0; i < 6; i++)
		begin
			s = 1'($urandom);
			pushed[i] = {s, VALS[i][78:0]};
			push(pushed[i]);
			op(8'he5, ev(CLS[i], s, 3'(7 - i)), 8'hff);
		end
		$display("test classify done");
		op(8'hc9, ev(3'h0, 1'b0, 3'h2), 8'h17);
		check("swap1", pushed[4], rd_data);
		op(8'hca, ev(3'h0, 1'b0, 3'h2), 8'h17);
		check("swap2", pushed[3], rd_data);
		$display("test swap done");
		push(80'h4002_8000_0000_0000_0000);
		op(8'hf4, ev(3'h0, 1'b0, 3'h0), 8'h17);
		check("signif", ONE, rd_data);
		rd_index <= 3'h1;
		@(posedge clk);
		check("exponent", 80'h4000_c000_0000_0000_0000, rd_data);
		rd_index <= 3'h0;
		op(8'hf4, ev(3'h0, 1'b1, 3'h0), 8'h17);
		rd(3'h0, 8'h41, "overflow");
		wr(3'h2, 8'h40);
		@(posedge clk);
		check("irq_on", 80'h1, irq);
		wr(3'h2, 8'h00);
		@(posedge clk);
		check("irq_masked", 80'h0, irq);
		wr(3'h2, 8'h40);
		wr(3'h1, 8'h41);
		wr(3'h0, 8'hff);
		@(posedge clk);
		check("irq_clr", 80'h0, irq);
		rd(3'h0, 8'h00, "cleared");
		$display("test extract done");
		for (int j = 0; j < 2; j++)
		begin
			emu_bit <= (j == 0);
			task_switched_bit <= (j == 1);
			op(8'he5, 8'h80, 8'h87);
		end
		emu_bit <= 1'b0;
		task_switched_bit <= 1'b0;
		$display("test fault done");
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		push(ONE);
		push(80'h4000_8000_0000_0000_0000);
		op(8'hf1, ev(3'h0, 1'b0, 3'h7), 8'h17);
		check("log_result", ONE, rd_data);
		rd_index <= 3'h7;
		@(posedge clk);
		check("popped", 80'h1, rd_empty);
		rd_index <= 3'h0;
		push(80'h0);
		op(8'hf1, ev(3'h0, 1'b0, 3'h7), 8'h07);
		check("log_zero", 80'hffff_8000_0000_0000_0000, rd_data);
		push(80'hbfff_8000_0000_0000_0000);
		op(8'hf1, ev(3'h0, 1'b0, 3'h7), 8'h07);
		rd(3'h0, 8'h05, "log_status");
		$display("test log done");
		wr(3'h1, 8'h7f);
		push(80'h8000_0000_0000_0000_0000);
		op(8'hf4, ev(3'h0, 1'b0, 3'h5), 8'h17);
		check("xz_top", 80'h8000_0000_0000_0000_0000, rd_data);
		push(80'h1);
		op(8'hf4, ev(3'h0, 1'b0, 3'h3), 8'h17);
		check("xd_sig", ONE, rd_data);
		rd_index <= 3'h1;
		@(posedge clk);
		check("xd_exp", 80'hc00d_807a_0000_0000_0000, rd_data);
		rd_index <= 3'h3;
		@(posedge clk);
		check("xz_exp", 80'hffff_8000_0000_0000_0000, rd_data);
		rd_index <= 3'h0;
		rd(3'h0, 8'h06, "x_flags");
		op(8'hf0, ev(3'h0, 1'b0, 3'h3), 8'h87);
		$display("test special done");
		complete_run();
	end
endmodule
